// [iau_chk.sv]
`timescale 1ns/1ps
module iau_chk
   import iau_pkg::*;
(
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic                pslverr,
   input wire logic                issue_valid,
   input wire iau_pkg::iau_issue_t issue,
   input wire logic                issue_ready,
   input wire logic                done_valid,
   input wire iau_pkg::iau_result_t done,
   input wire logic [3:0]          flags_field_zero,
   input wire logic [31:0]         fixed_point_exception_reg
);
   // ---------------------------------------------------------------
   // issue decode helpers
   // ---------------------------------------------------------------
   logic tk;
   logic dv;
   assign tk = issue_valid && issue_ready;
   assign dv = issue.op inside {iau_op_divw, iau_op_divwu};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   div_busy_a: assert property (tk && dv |=> !issue_ready [*8]) else $error("taken during divide");
   div_done_a: assert property (tk && dv |-> ##33 done_valid) else $error("divide late");
   op_done_a: assert property (tk && !dv |=> done_valid && done.dst == $past(issue.dst))
      else $error("no completion");
   addi_zero_a: assert property (tk && issue.op == iau_op_addi && issue.src_first == 5'h00 |=>
      done.value == {{16{$past(issue.signed_immediate[15])}}, $past(issue.signed_immediate)}) else $error("addi");
   addis_zero_a: assert property (tk && issue.op == iau_op_addis && issue.src_first == 5'h00 |=>
      done.value == {$past(issue.signed_immediate), 16'h0000}) else $error("addis");
   rec_flags_a: assert property (tk && !dv && issue.record_flag_bit |=> flags_field_zero ==
      {done.value[31], !done.value[31] && done.value != 32'h0000_0000, done.value == 32'h0000_0000,
       fixed_point_exception_reg[31]}) else $error("field zero");
   sticky_hold_a: assert property (fixed_point_exception_reg[31] &&
      !(psel && pwrite && paddr == IAU_OFF_EXCEPTION) |=> fixed_point_exception_reg[31]) else $error("sticky lost");
   bad_addr_a: assert property (psel && penable && paddr > IAU_OFF_STATUS |-> pslverr) else $error("no slverr");
endmodule
bind iau_unit iau_chk u_iau_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pslverr, .issue_valid,
   .issue, .issue_ready, .done_valid, .done, .flags_field_zero, .fixed_point_exception_reg);

// [iau_issuer.sv]
`timescale 1ns/1ps
module iau_issuer
   import iau_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                start,
   input  wire iau_pkg::iau_issue_t req,
   input  wire logic                issue_ready,
   output logic                     issue_valid,
   output iau_pkg::iau_issue_t      issue
);
   import iau_pkg::*;
   // request stands until the unit takes it
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         issue_valid <= 1'b0;
      else if (issue_valid && issue_ready)
         issue_valid <= 1'b0;
      else if (start)
         issue_valid <= 1'b1;
   // fields flip once taken so stale values never look valid
   always_ff @(posedge pclk)
      if (start)
         issue <= req;
      else if (issue_valid && issue_ready)
         issue <= ~issue;
endmodule

// [iau_pkg.sv]
package iau_pkg;

   // ---------------------------------------------------------------
   // operation codes accepted on the issue port
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      iau_op_addi, iau_op_addis, iau_op_add, iau_op_subf, iau_op_addic, iau_op_addic_rec,
      iau_op_subfic, iau_op_addc, iau_op_subfc, iau_op_adde, iau_op_subfe, iau_op_addme,
      iau_op_subfme, iau_op_addze, iau_op_subfze, iau_op_neg, iau_op_mulli, iau_op_mullw,
      iau_op_mulhw, iau_op_mulhwu, iau_op_divw, iau_op_divwu
   } iau_op_t;

   // ---------------------------------------------------------------
   // issue request and completion carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      iau_op_t     op;
      logic [4:0]  dst;
      logic [4:0]  src_first;
      logic [4:0]  src_second;
      logic [15:0] signed_immediate;
      logic        record_flag_bit;
      logic        excess_enable;
   } iau_issue_t;

   typedef struct packed {
      logic [4:0]  dst;
      logic [31:0] value;
   } iau_result_t;

   // ---------------------------------------------------------------
   // apb register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] IAU_OFF_EXCEPTION = 8'h00;
   localparam logic [7:0] IAU_OFF_FLAGS     = 8'h04;
   localparam logic [7:0] IAU_OFF_REG_INDEX = 8'h08;
   localparam logic [7:0] IAU_OFF_REG_DATA  = 8'h0c;
   localparam logic [7:0] IAU_OFF_STATUS    = 8'h10;

   // ---------------------------------------------------------------
   // field positions (bit 0 of the big-endian numbering is bit 31 here)
   // ---------------------------------------------------------------
   localparam int IAU_EXC_STICKY_BIT = 31;
   localparam int IAU_EXC_EXCESS_BIT = 30;
   localparam int IAU_EXC_COUT_BIT   = 29;
   localparam int IAU_FZ_LT_BIT      = 3;
   localparam int IAU_FZ_GT_BIT      = 2;
   localparam int IAU_FZ_EQ_BIT      = 1;
   localparam int IAU_FZ_STICKY_BIT  = 0;
   localparam int IAU_ST_BUSY_BIT    = 0;

   // ---------------------------------------------------------------
   // reset values and counts
   // ---------------------------------------------------------------
   localparam logic [31:0] IAU_REG_RESET   = 32'h0000_0000;
   localparam logic        IAU_FLAG_RESET  = 1'b0;
   localparam logic [3:0]  IAU_FZ_RESET    = 4'h0;
   localparam logic [4:0]  IAU_INDEX_RESET = 5'h00;
   localparam logic [4:0]  IAU_DIV_LAST    = 5'h1f;
   localparam logic [31:0] IAU_ALL_ONES    = 32'hffff_ffff;

endpackage

// [iau_unit.sv]
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Notes on behaviour
// - operands come from and results go to the register file; signed unless unsigned op
// - record forms and immediate carrying record add set field zero from sign of result
// - carrying, extended, minus-one and zero-extended forms always write carry out
// - overflow-enabled forms write overflow and set sticky overflow on signed overflow
// - field zero and exception flags describe the exact value written
// - add immediate: first source or zero plus sign-extended immediate
// - add immediate high: first source or zero plus immediate shifted up 16
// - subtract-from: complemented first source plus second source plus one
// - immediate carrying add sets carry; record variant updates field zero
// - subtract-from-immediate: complemented first plus immediate plus one, sets carry
// - extended forms use current carry as carry-in instead of zero (add) or one (subtract-from)
// - minus-one forms add first or complement, carry and all-ones
// - zero forms add only carry to first source or its complement
// - negate writes complemented first source plus one
// - multiply-low-immediate writes low 32 bits of first times immediate
// - multiply-low-word writes low 32 bits of register product
// - signed multiply-high writes upper 32 bits of signed 64-bit product
// - unsigned multiply-high writes upper 32 bits of unsigned 64-bit product
// - signed divide writes the quotient only
// - unsigned divide writes quotient of zero-extended sources
// - only the divide forms stall following issue, for 32 clocks until the quotient is written
// ---------------------------------------------------------------
module iau_unit
   import iau_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 issue_valid,
   input  wire iau_pkg::iau_issue_t  issue,
   output logic                      issue_ready,
   output logic                      done_valid,
   output iau_pkg::iau_result_t      done,
   output logic [3:0]                flags_field_zero,
   output logic [31:0]               fixed_point_exception_reg
);
   import iau_pkg::*;

   typedef enum logic {iau_st_idle, iau_st_div} iau_state_t;

   // ---------------------------------------------------------------
   // architectural state
   // ---------------------------------------------------------------
   logic [31:0] general_register_file [32];
   logic        arith_cout_bit;
   logic        arith_excess_flag;
   logic        sticky_excess;
   logic [4:0]  reg_index;
   iau_state_t  state;

   // divider state
   logic [31:0] div_rem;
   logic [31:0] div_quo;
   logic [31:0] div_den;
   logic [4:0]  div_cnt;
   logic        div_neg;
   logic        div_ovf;
   logic        div_rec;
   logic        div_oe;
   logic [4:0]  div_dst;

   // ---------------------------------------------------------------
   // operand fetch
   // ---------------------------------------------------------------
   logic [31:0] val_first;
   logic [31:0] val_second;
   logic [31:0] signed_immediate_ext;
   logic        is_div;
   logic        take;
   logic        div_start;
   logic        div_finish;

   // reads are combinational so a single-cycle op completes on its issue edge
   assign val_first  = general_register_file[issue.src_first];
   assign val_second = general_register_file[issue.src_second];
   assign signed_immediate_ext   = {{16{issue.signed_immediate[15]}}, issue.signed_immediate};
   assign is_div     = (issue.op == iau_op_divw) || (issue.op == iau_op_divwu);
   // the divider holds off all issue while it iterates
   assign issue_ready = (state == iau_st_idle);
   assign take        = issue_valid && issue_ready && !is_div;
   assign div_start   = issue_valid && issue_ready && is_div;
   assign div_finish  = (state == iau_st_div) && (div_cnt == IAU_DIV_LAST);

   // ---------------------------------------------------------------
   // adder operand selection
   // ---------------------------------------------------------------
   logic [31:0] add_a;
   logic [31:0] add_b;
   logic        add_cin;
   logic        sets_carry;
   logic        oe_allowed;

   always_comb
   begin
      add_a      = val_first;
      add_b      = val_second;
      add_cin    = 1'b0;
      sets_carry = 1'b0;
      oe_allowed = 1'b1;
      case (issue.op)
         iau_op_addi:
         begin
            add_a      = (issue.src_first == 5'h00) ? 32'h0000_0000 : val_first;
            add_b      = signed_immediate_ext;
            oe_allowed = 1'b0;
         end
         iau_op_addis:
         begin
            add_a      = (issue.src_first == 5'h00) ? 32'h0000_0000 : val_first;
            add_b      = {issue.signed_immediate, 16'h0000};
            oe_allowed = 1'b0;
         end
         iau_op_add: add_b = val_second;
         iau_op_subf:
         begin
            add_a   = ~val_first;
            add_cin = 1'b1;
         end
         iau_op_addic, iau_op_addic_rec:
         begin
            add_b      = signed_immediate_ext;
            sets_carry = 1'b1;
            oe_allowed = 1'b0;
         end
         iau_op_subfic:
         begin
            add_a      = ~val_first;
            add_b      = signed_immediate_ext;
            add_cin    = 1'b1;
            sets_carry = 1'b1;
            oe_allowed = 1'b0;
         end
         iau_op_addc: sets_carry = 1'b1;
         iau_op_subfc:
         begin
            add_a      = ~val_first;
            add_cin    = 1'b1;
            sets_carry = 1'b1;
         end
         iau_op_adde, iau_op_subfe:
         begin
            add_a      = (issue.op == iau_op_subfe) ? ~val_first : val_first;
            add_cin    = arith_cout_bit;
            sets_carry = 1'b1;
         end
         iau_op_addme, iau_op_subfme:
         begin
            add_a      = (issue.op == iau_op_subfme) ? ~val_first : val_first;
            add_b      = IAU_ALL_ONES;
            add_cin    = arith_cout_bit;
            sets_carry = 1'b1;
         end
         iau_op_addze, iau_op_subfze:
         begin
            add_a      = (issue.op == iau_op_subfze) ? ~val_first : val_first;
            add_b      = 32'h0000_0000;
            add_cin    = arith_cout_bit;
            sets_carry = 1'b1;
         end
         iau_op_neg:
         begin
            add_a   = ~val_first;
            add_b   = 32'h0000_0000;
            add_cin = 1'b1;
         end
         iau_op_mulhw, iau_op_mulhwu: oe_allowed = 1'b0;
         iau_op_mulli: oe_allowed = 1'b0;
         default: add_cin = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // adder, multiplier and single-cycle result
   // ---------------------------------------------------------------
   logic [32:0] add_sum;
   logic        add_ovf;
   logic [63:0] mul_signed;
   logic [63:0] mul_unsigned;
   logic [63:0] mul_imm;
   logic [31:0] alu_val;
   logic        alu_ovf;
   logic        alu_rec;

   assign add_sum = {1'b0, add_a} + {1'b0, add_b} + {32'h0000_0000, add_cin};
   // signed overflow: operands agree in sign, result does not
   assign add_ovf = (add_a[31] == add_b[31]) && (add_sum[31] != add_a[31]);
   assign mul_signed   = 64'($signed(val_first) * $signed(val_second));
   assign mul_unsigned = 64'(val_first * val_second);
   assign mul_imm      = 64'($signed(val_first) * $signed(signed_immediate_ext));
   assign alu_rec = issue.record_flag_bit || (issue.op == iau_op_addic_rec);

   always_comb
   begin
      alu_val = add_sum[31:0];
      alu_ovf = add_ovf;
      case (issue.op)
         iau_op_mulli:
         begin
            alu_val = mul_imm[31:0];
            alu_ovf = 1'b0;
         end
         iau_op_mullw:
         begin
            alu_val = mul_signed[31:0];
            // overflow when the product does not fit a signed word
            alu_ovf = (mul_signed[63:32] != {32{mul_signed[31]}});
         end
         iau_op_mulhw:
         begin
            alu_val = mul_signed[63:32];
            alu_ovf = 1'b0;
         end
         iau_op_mulhwu:
         begin
            alu_val = mul_unsigned[63:32];
            alu_ovf = 1'b0;
         end
         default: alu_val = add_sum[31:0];
      endcase
   end

   // ---------------------------------------------------------------
   // iterative divider, one quotient bit per clock
   // ---------------------------------------------------------------
   logic [31:0] mag_first;
   logic [31:0] mag_second;
   logic        signed_div;
   logic [32:0] div_shift;
   logic [32:0] div_diff;
   logic        div_qbit;
   logic [31:0] div_quo_step;
   logic [31:0] div_quo_out;

   assign signed_div = (issue.op == iau_op_divw);
   assign mag_first  = (signed_div && val_first[31]) ? 32'(-val_first) : val_first;
   assign mag_second = (signed_div && val_second[31]) ? 32'(-val_second) : val_second;
   assign div_shift  = {div_rem, div_quo[31]};
   assign div_diff   = div_shift - {1'b0, div_den};
   assign div_qbit   = !div_diff[32];
   assign div_quo_step = {div_quo[30:0], div_qbit};
   // quotient only; the remainder is discarded
   assign div_quo_out  = div_neg ? 32'(-div_quo_step) : div_quo_step;

   // state: a division occupies 32 clocks after its issue edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= iau_st_idle;
      else if (div_start)
         state <= iau_st_div;
      else if (div_finish)
         state <= iau_st_idle;
   end

   // divider datapath; unsigned form sees both operands zero-extended
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_rem <= 32'h0000_0000;
         div_quo <= 32'h0000_0000;
         div_den <= 32'h0000_0000;
         div_cnt <= 5'h00;
         div_neg <= 1'b0;
         div_ovf <= 1'b0;
         div_rec <= 1'b0;
         div_oe  <= 1'b0;
         div_dst <= 5'h00;
      end
      else if (div_start)
      begin
         div_rem <= 32'h0000_0000;
         div_quo <= mag_first;
         div_den <= mag_second;
         div_cnt <= 5'h00;
         div_neg <= signed_div && (val_first[31] ^ val_second[31]);
         // zero divisor, or most-negative by minus one in the signed form
         div_ovf <= (val_second == 32'h0000_0000) ||
                    (signed_div && val_first == 32'h8000_0000 && val_second == IAU_ALL_ONES);
         div_rec <= issue.record_flag_bit;
         div_oe  <= issue.excess_enable;
         div_dst <= issue.dst;
      end
      else if (state == iau_st_div)
      begin
         div_rem <= div_qbit ? div_diff[31:0] : div_shift[31:0];
         div_quo <= div_quo_step;
         div_cnt <= 5'(div_cnt + 5'h01);
      end
   end

   // ---------------------------------------------------------------
   // writeback selection
   // ---------------------------------------------------------------
   logic        wb_en;
   logic [4:0]  wb_dst;
   logic [31:0] wb_val;
   logic        wb_rec;
   logic        wb_cout_en;
   logic        wb_excess_en;
   logic        wb_excess;

   always_comb
   begin
      wb_en    = take || div_finish;
      wb_dst   = div_finish ? div_dst : issue.dst;
      wb_val   = div_finish ? div_quo_out : alu_val;
      wb_rec   = div_finish ? div_rec : alu_rec;
      wb_cout_en   = take && sets_carry;
      wb_excess_en = div_finish ? div_oe : (take && issue.excess_enable && oe_allowed);
      wb_excess    = div_finish ? div_ovf : alu_ovf;
   end

   // ---------------------------------------------------------------
   // apb slave decode
   // ---------------------------------------------------------------
   logic apb_wr;
   logic apb_mapped;

   // a register-file access from software waits while the unit writes back
   assign pready  = !(wb_en && (paddr == IAU_OFF_REG_DATA));
   assign apb_mapped = (paddr == IAU_OFF_EXCEPTION) || (paddr == IAU_OFF_FLAGS) ||
                       (paddr == IAU_OFF_REG_INDEX) || (paddr == IAU_OFF_REG_DATA) ||
                       (paddr == IAU_OFF_STATUS);
   assign pslverr = psel && penable && !apb_mapped;
   assign apb_wr  = psel && penable && pready && pwrite && apb_mapped && pstrb[3];

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 32; i++)
            general_register_file[i] <= IAU_REG_RESET;
      end
      else if (wb_en)
         general_register_file[wb_dst] <= wb_val;
      else if (apb_wr && paddr == IAU_OFF_REG_DATA)
         general_register_file[reg_index] <= pwdata;
   end

   // software window index
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reg_index <= IAU_INDEX_RESET;
      else if (apb_wr && paddr == IAU_OFF_REG_INDEX)
         reg_index <= pwdata[4:0];
   end

   // ---------------------------------------------------------------
   // exception flags; hardware update wins over a simultaneous write
   // ---------------------------------------------------------------
   logic next_sticky;

   always_comb
   begin
      next_sticky = sticky_excess;
      if (apb_wr && paddr == IAU_OFF_EXCEPTION)
         next_sticky = pwdata[IAU_EXC_STICKY_BIT];
      if (wb_excess_en && wb_excess)
         next_sticky = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         arith_cout_bit    <= IAU_FLAG_RESET;
         arith_excess_flag <= IAU_FLAG_RESET;
         sticky_excess     <= IAU_FLAG_RESET;
      end
      else
      begin
         sticky_excess <= next_sticky;
         if (wb_cout_en)
            arith_cout_bit <= add_sum[32];
         else if (apb_wr && paddr == IAU_OFF_EXCEPTION)
            arith_cout_bit <= pwdata[IAU_EXC_COUT_BIT];
         if (wb_excess_en)
            arith_excess_flag <= wb_excess;
         else if (apb_wr && paddr == IAU_OFF_EXCEPTION)
            arith_excess_flag <= pwdata[IAU_EXC_EXCESS_BIT];
      end
   end

   // ---------------------------------------------------------------
   // condition field zero, taken from the value actually written
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags_field_zero <= IAU_FZ_RESET;
      else if (wb_en && wb_rec)
      begin
         flags_field_zero[IAU_FZ_LT_BIT] <= wb_val[31];
         flags_field_zero[IAU_FZ_GT_BIT] <= !wb_val[31] && (wb_val != 32'h0000_0000);
         flags_field_zero[IAU_FZ_EQ_BIT] <= (wb_val == 32'h0000_0000);
         flags_field_zero[IAU_FZ_STICKY_BIT] <= next_sticky;
      end
      else if (apb_wr && paddr == IAU_OFF_FLAGS)
         flags_field_zero <= pwdata[3:0];
   end

   always_comb
   begin
      fixed_point_exception_reg = 32'h0000_0000;
      fixed_point_exception_reg[IAU_EXC_STICKY_BIT] = sticky_excess;
      fixed_point_exception_reg[IAU_EXC_EXCESS_BIT] = arith_excess_flag;
      fixed_point_exception_reg[IAU_EXC_COUT_BIT]   = arith_cout_bit;
   end

   // ---------------------------------------------------------------
   // completion report
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done_valid <= 1'b0;
         done       <= '0;
      end
      else
      begin
         done_valid <= wb_en;
         if (wb_en)
         begin
            done.dst   <= wb_dst;
            done.value <= wb_val;
         end
      end
   end

   // ---------------------------------------------------------------
   // apb read data
   // ---------------------------------------------------------------
   always_comb
   begin
      prdata = 32'h0000_0000;
      case (paddr)
         IAU_OFF_EXCEPTION: prdata = fixed_point_exception_reg;
         IAU_OFF_FLAGS:     prdata = {28'h0000000, flags_field_zero};
         IAU_OFF_REG_INDEX: prdata = {27'h000_0000, reg_index};
         IAU_OFF_REG_DATA:  prdata = general_register_file[reg_index];
         IAU_OFF_STATUS:    prdata[IAU_ST_BUSY_BIT] = (state == iau_st_div);
         default:           prdata = 32'h0000_0000;
      endcase
   end

endmodule

// [tb_integer_arithmetic_unit.sv]
`timescale 1ns/1ps
module tb_integer_arithmetic_unit;
   import iau_pkg::*;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, start = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, fixed_point_exception_reg;
   logic pready, pslverr, issue_valid, issue_ready, done_valid;
   logic [3:0] flags_field_zero;
   iau_issue_t issue, req = '0;
   iau_result_t done;
   int num_errors = 0, n_compared = 0;
   always #20 pclk = ~pclk;
   iau_unit u_iau_unit (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
      .pready, .pslverr, .issue_valid, .issue, .issue_ready, .done_valid, .done, .flags_field_zero,
      .fixed_point_exception_reg);
   iau_issuer u_iau_issuer (.pclk, .presetn, .start, .req, .issue_ready, .issue_valid, .issue);
   // ---------------------------------------------------------------
   // bus and issue tasks
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // sample and release only on the rising edge that completes the access
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      q = prdata; e = pslverr;
      if (pready !== 1'b1) num_errors++;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic op(input int o, input logic [4:0] a, input logic oe, output logic [31:0] v);
      int n;
      @(posedge pclk);
      req <= '{iau_op_t'(o), 5'h03, a, 5'h02, 16'hfff0, 1'b1, oe}; start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      n = 0;
      do begin @(negedge pclk); n++; end while (done_valid !== 1'b1 && n < 60);
      if (done_valid !== 1'b1) num_errors++;
      v = done.value;
   endtask
   task automatic set_reg(input logic [4:0] i, input logic [31:0] d);
      logic [31:0] q; logic e;
      apb(1'b1, IAU_OFF_REG_INDEX, {27'h0, i}, q, e);
      apb(1'b1, IAU_OFF_REG_DATA, d, q, e);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      logic [31:0] q; logic e;
      apb(1'b0, IAU_OFF_EXCEPTION, 32'h0000_0000, q, e);
      `CHK(q, 32'h0000_0000)
      apb(1'b0, 8'h14, 32'h0000_0000, q, e);
      `CHK(e, 1'b1)
      $display("t_regs done");
   endtask
   // every opcode against a reference sum, product or quotient with tracked carry
   task automatic t_arith;
      logic [31:0] a, b, x, y, r, v; logic [32:0] s; logic [63:0] w; logic ca, ci;
      a = 32'h8000_0003; b = 32'h0000_0005; ca = 1'b0;
      set_reg(5'h01, a); set_reg(5'h02, b);
      for (int i = 0; i <= 21; i++)
      begin
         x = (i inside {3, 6, 8, 10, 12, 14, 15}) ? ~a : a;
         y = (i inside {2, 3, 7, 8, 9, 10}) ? b : (i == 1) ? 32'hfff0_0000 : (i inside {11, 12}) ? IAU_ALL_ONES
            : (i inside {13, 14, 15}) ? 32'h0000_0000 : 32'hffff_fff0;
         ci = (i inside {3, 6, 8, 15}) ? 1'b1 : (i inside {[9:14]}) ? ca : 1'b0;
         s = {1'b0, x} + {1'b0, y} + {32'h0000_0000, ci};
         if (i inside {[4:14]}) ca = s[32];
         case (i)
            16: w = a * 32'hffff_fff0;
            18: w = $signed(a) * $signed(b);
            20: w = $signed(a) / $signed(b);
            21: w = a / b;
            default: w = a * b;
         endcase
         r = (i < 16) ? s[31:0] : (i inside {18, 19}) ? w[63:32] : w[31:0];
         op(i, 5'h01, 1'b0, v);
         `CHK(v, r)
         `CHK(fixed_point_exception_reg[29], ca)
         `CHK(flags_field_zero, {r[31], !r[31] && r != 32'h0000_0000, r == 32'h0000_0000, 1'b0})
      end
      $display("t_arith done");
   endtask
   // overflow, sticky hold, software clear, divide by zero
   task automatic t_ovf;
      logic [31:0] v, q; logic e;
      set_reg(5'h01, 32'h7fff_ffff); set_reg(5'h02, 32'h0000_0001);
      op(2, 5'h01, 1'b1, v);
      `CHK(fixed_point_exception_reg[31:30], 2'b11)
      op(2, 5'h02, 1'b1, v);
      `CHK(fixed_point_exception_reg[31:30], 2'b10)
      `CHK(flags_field_zero[0], 1'b1)
      apb(1'b1, IAU_OFF_EXCEPTION, 32'h0000_0000, q, e);
      apb(1'b0, IAU_OFF_EXCEPTION, 32'h0000_0000, q, e);
      `CHK(q, 32'h0000_0000)
      set_reg(5'h02, 32'h0000_0000);
      op(21, 5'h01, 1'b1, v);
      `CHK(fixed_point_exception_reg[30], 1'b1)
      $display("t_ovf done");
   endtask
   task automatic stop_test;
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // main sequence and watchdog
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs; t_arith; t_ovf;
      stop_test;
   end
   initial
   begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      stop_test;
   end
endmodule
